// file: hw/hall_switch.sv
// Duty-cycled wake sequencer and omnipolar threshold decision of the hall switch
`timescale 1ns/1ns
`include "hall_switch_regs.svh"
module hall_switch
    import hall_switch_pkg::*;
#(
    parameter logic [23:0] PERIOD_CYCLES = 24'(`SAMPLING_PERIOD_CYCLES),
    parameter logic [15:0] TRIM_CYCLES = 16'(`TRIM_CYCLES),
    parameter logic [15:0] CONVERT_CYCLES = 16'(`CONVERT_CYCLES),
    parameter logic [15:0] POWER_ON_CYCLES = 16'(`POWER_ON_CYCLES)
)
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic signed [15:0] field_in,
    input wire logic set_mode_in,
    input wire logic [15:0] set_code_in,
    output logic out_level_out,
    output logic set_source_en_out,
    output logic trim_load_out,
    output logic convert_en_out,
    output logic sleep_out
);
    localparam logic [15:0] SETTLE_LEN = 16'(`SETTLE_CYCLES);

    // Field in microtesla, positive when flux runs bottom to top of the package
    function automatic logic [16:0] field_magnitude(input logic signed [15:0] f);
        logic [16:0] wide;
        wide = {f[15], f};
        return f[15] ? 17'(-wide) : wide;
    endfunction : field_magnitude

    // Operate threshold in microtesla from the set pin reading
    function automatic logic [20:0] operate_from_pin(input logic mode, input logic [15:0] code);
        logic [20:0] wide;
        wide = {5'h0, code};
        if (mode == set_voltage)
            return 21'((wide * `VOLT_SCALE_NUM) >> 1);
        else
            return wide;
    endfunction : operate_from_pin

    seq_state_t state;
    seq_state_t next_state;
    logic [23:0] period_cnt;
    logic [16:0] sample_mag;
    logic [20:0] operate_threshold;
    logic [20:0] release_threshold;
    logic wake;
    logic phase_done;
    logic reach_operate;
    logic below_release;
    logic next_level;

    phase_if pif();

    phase_timer u_timer
    (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .tmr(pif)
    );

    // Free-running oscillator divider; reset lands on the last count so the
    // first sample starts right after reset and ends well inside power-on time
    assign wake = (period_cnt == PERIOD_CYCLES - 24'h1);
    assign phase_done = pif.done;

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            period_cnt <= PERIOD_CYCLES - 24'h1;
        else
            period_cnt <= wake ? 24'h0 : period_cnt + 24'h1;
    end

    // Strict phase order; a wake seen while still active is skipped
    always_comb
    begin
        next_state = state;
        case (state)
            st_sleep: next_state = wake ? st_trim : st_sleep;
            st_trim: next_state = phase_done ? st_settle : st_trim;
            st_settle: next_state = phase_done ? st_convert : st_settle;
            st_convert: next_state = phase_done ? st_latch : st_convert;
            st_latch: next_state = st_sleep;
            default: next_state = st_sleep;
        endcase
    end

    // Phase timer loads on every entry to a timed phase
    assign pif.start = (next_state != state) && (next_state inside {st_trim, st_settle, st_convert});
    assign pif.length = (next_state == st_trim) ? TRIM_CYCLES :
                        (next_state == st_settle) ? SETTLE_LEN : CONVERT_CYCLES;

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            state <= st_sleep;
        else
            state <= next_state;
    end

    // Field and set pin are captured at the end of conversion, after the
    // source has settled, so a pin change in sleep shows at the next wake
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            sample_mag <= 17'h0;
            operate_threshold <= 21'h0;
        end
        else if (state == st_convert && phase_done)
        begin
            sample_mag <= field_magnitude(field_in);
            operate_threshold <= operate_from_pin(set_mode_in, set_code_in);
        end
    end

    // Fixed hysteresis; clamped at zero so a tiny operate value cannot wrap
    assign release_threshold = (operate_threshold >= `HYSTERESIS_UT) ?
                               operate_threshold - `HYSTERESIS_UT : 21'h0;
    assign reach_operate = ({4'h0, sample_mag} >= operate_threshold);
    assign below_release = ({4'h0, sample_mag} < release_threshold);
    assign next_level = reach_operate ? 1'b0 : (below_release ? 1'b1 : out_level_out);

    // Output latch only moves in the latch step; held through sleep
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            out_level_out <= `OUT_RESET_LEVEL;
        else if (state == st_latch)
            out_level_out <= next_level;
    end

    // Phase indicators registered from the next state
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            set_source_en_out <= 1'b0;
            trim_load_out <= 1'b0;
            convert_en_out <= 1'b0;
            sleep_out <= 1'b1;
        end
        else
        begin
            set_source_en_out <= (next_state == st_settle) || (next_state == st_convert);
            trim_load_out <= (next_state == st_trim);
            convert_en_out <= (next_state == st_convert);
            sleep_out <= (next_state == st_sleep);
        end
    end

    // Helper state for the checks below
    logic first_done;
    logic [15:0] since_reset;
    logic [15:0] trim_cnt;
    logic [15:0] source_on_cnt;
    logic [15:0] conv_cnt;

    // Per-phase cycle counters; each clears when its indicator drops, so the
    // length checks see exactly one phase at a time
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            trim_cnt <= 16'h0;
            source_on_cnt <= 16'h0;
            conv_cnt <= 16'h0;
        end
        else
        begin
            trim_cnt <= trim_load_out ? trim_cnt + 16'h1 : 16'h0;
            source_on_cnt <= set_source_en_out ? source_on_cnt + 16'h1 : 16'h0;
            conv_cnt <= convert_en_out ? conv_cnt + 16'h1 : 16'h0;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            first_done <= 1'b0;
            since_reset <= 16'h0;
        end
        else
        begin
            first_done <= first_done || (state == st_latch);
            since_reset <= (since_reset == POWER_ON_CYCLES) ? since_reset : since_reset + 16'h1;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence settle_entry;
        $fell(trim_load_out) ##0 set_source_en_out && !convert_en_out;
    endsequence

    sequence convert_entry;
        $rose(convert_en_out) ##0 set_source_en_out && !trim_load_out;
    endsequence

    chk_first_sample: assert property ((since_reset == POWER_ON_CYCLES) |-> first_done)
        else $error("first sample not done within power-on time");
    chk_sleep_source: assert property (sleep_out |-> !set_source_en_out && !convert_en_out)
        else $error("set source or conversion on during sleep");
    chk_sleep_hold: assert property (sleep_out && $past(sleep_out) |-> $stable(out_level_out))
        else $error("output moved while asleep");
    chk_trim_to_settle: assert property ($fell(trim_load_out) |-> settle_entry)
        else $error("trim load not followed by settle");
    chk_settle_to_conv: assert property ($rose(convert_en_out) |-> convert_entry ##0 $past(set_source_en_out))
        else $error("conversion began without settled source");
    chk_wake_spacing: assert property ($rose(trim_load_out) |-> period_cnt == 24'h0)
        else $error("wake not aligned to sampling period");
    chk_operate_low: assert property (state == st_latch && reach_operate |=> !out_level_out)
        else $error("output not low at operate threshold");
    chk_release_high: assert property (state == st_latch && below_release |=> out_level_out)
        else $error("output not high below release threshold");
    chk_hold_band: assert property (state == st_latch && !reach_operate && !below_release
        |=> $stable(out_level_out))
        else $error("output changed inside hysteresis band");
    // Expected threshold worked out here on its own: 1 uT per ohm, 12.5 uT per millivolt
    chk_pin_reread: assert property (state == st_convert && phase_done
        |=> operate_threshold == ($past(set_mode_in) ? 21'(({5'h0, $past(set_code_in)} * 21'h19) >> 1)
        : {5'h0, $past(set_code_in)}))
        else $error("operate threshold not refreshed from set pin");
    chk_trim_length: assert property ($fell(trim_load_out) |-> trim_cnt == TRIM_CYCLES)
        else $error("trim phase length wrong");
    chk_settle_length: assert property ($rose(convert_en_out) |-> source_on_cnt == SETTLE_LEN)
        else $error("conversion began before source settle time");
    chk_convert_length: assert property ($fell(convert_en_out) |-> conv_cnt == CONVERT_CYCLES)
        else $error("conversion phase length wrong");
    chk_latch_single: assert property (state == st_latch |=> state == st_sleep && sleep_out)
        else $error("latch step not followed by sleep");
endmodule : hall_switch

// file: hw/hall_switch_regs.svh
// Timing, threshold and reset constants for the duty-cycled hall threshold switch
// Contract
// - First sample taken and output valid before the power-on time ends.
// - Output held in a latch between samples; device sleeps until next wake.
// - Output changes only when the new decision differs from the latched level.
// - Wake-ups spaced one sampling period apart, nominally 50 ms.
// - First active phase loads trim memory for about 35 us.
// - Second active phase enables and settles the set current source, 5 us.
// - Final active phase converts the field for about 25 us.
// - 80 uA set current source on only while active, off during sleep.
// - Threshold set pin re-read every active interval; latency one period.
// - Resistor mode: operate threshold in mT equals resistance in kOhm, 2 to 15.
// - Voltage mode: operate threshold mT equals millivolts times 0.0125, 160 to 1200.
// - Release threshold sits a fixed 1 mT hysteresis below operate threshold.
// - Decision is omnipolar, comparing field magnitude.
// - Flux from package bottom toward top counts as positive.
// - With no field present the output comes up high.
`ifndef HALL_SWITCH_REGS_SVH
`define HALL_SWITCH_REGS_SVH

`define CLK_MHZ 32'hFA
`define SAMPLING_PERIOD_MS 32'h32
`define POWER_ON_TIME_US 32'h7D
`define TRIM_TIME_US 32'h23
`define SETTLE_TIME_US 32'h5
`define CONVERT_TIME_US 32'h19
`define SAMPLING_PERIOD_CYCLES (`SAMPLING_PERIOD_MS * 32'h3E8 * `CLK_MHZ)
`define POWER_ON_CYCLES (`POWER_ON_TIME_US * `CLK_MHZ)
`define TRIM_CYCLES (`TRIM_TIME_US * `CLK_MHZ)
`define SETTLE_CYCLES (`SETTLE_TIME_US * `CLK_MHZ)
`define CONVERT_CYCLES (`CONVERT_TIME_US * `CLK_MHZ)
`define HYSTERESIS_UT 21'h3E8
`define VOLT_SCALE_NUM 21'h19
`define OUT_RESET_LEVEL 1'b1

`endif

// file: hw/hall_switch_pkg.sv
// Types shared by the hall threshold switch sequencer and its phase timer
package hall_switch_pkg;

    typedef enum logic [2:0]
    {
        st_sleep = 3'h0,
        st_trim = 3'h1,
        st_settle = 3'h2,
        st_convert = 3'h3,
        st_latch = 3'h4
    } seq_state_t;

    typedef enum logic
    {
        set_resistor = 1'b0,
        set_voltage = 1'b1
    } set_mode_t;

endpackage : hall_switch_pkg

// file: hw/phase_if.sv
// Start, length and done handshake between the sequencer and its phase timer
`timescale 1ns/1ns
interface phase_if;
    logic start;
    logic [15:0] length;
    logic done;

    modport ctrl
    (
        output start,
        output length,
        input done
    );

    modport timer
    (
        input start,
        input length,
        output done
    );
endinterface : phase_if

// file: hw/phase_timer.sv
// Down-counter that times one active phase of the sequencer
`timescale 1ns/1ns
module phase_timer
    import hall_switch_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    phase_if.timer tmr
);
    logic [15:0] remain;
    logic busy;
    logic last;

    // Done marks the last cycle of a phase that lasts exactly length cycles
    assign last = busy && (remain == 16'h1);
    assign tmr.done = last;

    // A new start always reloads, so back-to-back phases need no idle cycle
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            remain <= 16'h0;
            busy <= 1'b0;
        end
        else if (tmr.start)
        begin
            remain <= tmr.length;
            busy <= 1'b1;
        end
        else if (busy)
        begin
            remain <= remain - 16'h1;
            busy <= !last;
        end
    end

    chk_done_single: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        tmr.done |=> !tmr.done || $past(tmr.start))
        else $error("phase done held longer than one cycle");
endmodule : phase_timer

// file: test/hall_field_source.sv
// Magnet and threshold-set source model facing the hall switch pins
`timescale 1ns/1ns
module hall_field_source
#(
    parameter int SETTLE_CYCLES = 1000
)
(
    input wire logic clk_in,
    input wire logic source_en_in,
    input wire logic mode_in,
    input wire logic [15:0] code_in,
    input wire logic signed [15:0] flux_in,
    output logic set_mode_out,
    output logic [15:0] set_code_out,
    output logic signed [15:0] field_out
);
    int settle = 0;

    // Counts how long the set pin has been under the current source
    always @(posedge clk_in)
    begin
        settle <= source_en_in ? settle + 1 : 0;
    end

    // Unsettled or unpowered pin shows the inverse, so a read at the wrong moment is caught
    assign set_code_out = (source_en_in && settle >= SETTLE_CYCLES) ? code_in : ~code_in;
    assign set_mode_out = mode_in;
    assign field_out = flux_in;
endmodule : hall_field_source

// file: test/tb.sv
// Self-checking bench for the duty-cycled hall threshold switch
`timescale 1ns/1ns
`define CHECK(got, exp, msg) \
    begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
    $display("CHECK FAILED at %0t: %s", $time, msg); end end
module tb
    import hall_switch_pkg::*;
;
    localparam int T = 20;
    localparam int S = 1250;
    localparam int C = 20;
    localparam int P = 4000;
    localparam int PON = 2000;
    typedef struct {logic mode; logic [15:0] code; logic signed [15:0] flux; logic exp;} row_t;
    logic clk_in;
    logic reset_n_in;
    logic signed [15:0] field_in;
    logic set_mode_in;
    logic [15:0] set_code_in;
    logic out_level_out;
    logic set_source_en_out;
    logic trim_load_out;
    logic convert_en_out;
    logic sleep_out;
    logic mode;
    logic [15:0] code;
    logic signed [15:0] flux;
    int fail_count = 0;
    int checks_done = 0;
    int ntrim = 0;
    int nset = 0;
    int nconv = 0;
    int first_sleep = 0;
    int next_wake = 0;
    int overlap = 0;
    // Rows run in order: hysteresis makes each row depend on the one before
    row_t rows [14] = '{
        '{set_resistor, 16'h1388, 16'sh0000, 1'b1}, '{set_resistor, 16'h1388, 16'sh1387, 1'b1},
        '{set_resistor, 16'h1388, 16'sh1388, 1'b0}, '{set_resistor, 16'h1388, 16'sh0FA1, 1'b0},
        '{set_resistor, 16'h1388, 16'sh0F9F, 1'b1}, '{set_resistor, 16'h1388, -16'sh1388, 1'b0},
        '{set_resistor, 16'h1388, -16'sh0F9F, 1'b1}, '{set_voltage, 16'h0190, 16'sh1388, 1'b0},
        '{set_voltage, 16'h0190, 16'sh0F9F, 1'b1}, '{set_voltage, 16'h00A0, -16'sh07D0, 1'b0},
        '{set_voltage, 16'h00A0, 16'sh03E7, 1'b1}, '{set_resistor, 16'h3A98, 16'sh3A97, 1'b1},
        '{set_voltage, 16'h04B0, -16'sh3A98, 1'b0}, '{set_voltage, 16'h04B0, -16'sh36AF, 1'b1}};

    hall_switch #(.PERIOD_CYCLES(24'h000FA0), .TRIM_CYCLES(16'h0014), .CONVERT_CYCLES(16'h0014),
        .POWER_ON_CYCLES(16'h07D0)) dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .field_in(field_in),
        .set_mode_in(set_mode_in), .set_code_in(set_code_in), .out_level_out(out_level_out),
        .set_source_en_out(set_source_en_out), .trim_load_out(trim_load_out),
        .convert_en_out(convert_en_out), .sleep_out(sleep_out));

    hall_field_source src_u (.clk_in(clk_in), .source_en_in(set_source_en_out), .mode_in(mode),
        .code_in(code), .flux_in(flux), .set_mode_out(set_mode_in), .set_code_out(set_code_in),
        .field_out(field_in));

    // Free-running 250 MHz clock
    initial
    begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    task automatic tick;
        @(posedge clk_in);
        #1;
    endtask : tick

    // Bounded wait; a stuck sequencer shows as a failed compare, not a hang
    task automatic wait_sleep(input logic lvl);
        int n;
        n = 0;
        while (sleep_out !== lvl && n < 5000)
        begin
            tick();
            n++;
        end
        `CHECK(sleep_out, lvl, "sleep level never reached")
    endtask : wait_sleep

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    // Watchdog sized well beyond the ~70k cycles the sequence needs
    initial
    begin
        #400000;
        fail_count++;
        end_of_test();
    end

    // Main sequence: phase walk, row table, then reset in mid-run
    initial
    begin
        reset_n_in = 1'b0;
        mode = set_resistor;
        code = 16'h1388;
        flux = 16'sh0000;
        repeat (2) @(posedge clk_in);
        #1;
        `CHECK({out_level_out, sleep_out, set_source_en_out, trim_load_out, convert_en_out}, 5'h18, "reset")
        reset_n_in = 1'b1;
        for (int n = 1; n <= P + 1; n++)
        begin
            tick();
            ntrim += (trim_load_out === 1'b1);
            nset += (set_source_en_out === 1'b1);
            nconv += (convert_en_out === 1'b1);
            overlap += (trim_load_out & (set_source_en_out | convert_en_out)) === 1'b1;
            overlap += (sleep_out & (trim_load_out | set_source_en_out | convert_en_out)) === 1'b1;
            overlap += (convert_en_out & ~set_source_en_out) === 1'b1;
            if (sleep_out === 1'b1 && first_sleep == 0)
                first_sleep = n;
            if (trim_load_out === 1'b1 && first_sleep != 0 && next_wake == 0)
                next_wake = n;
        end
        `CHECK(ntrim, T + 1, "trim phase length")
        `CHECK(nset, S + C, "source on time")
        `CHECK(nconv, C, "conversion length")
        `CHECK(first_sleep, 2 + T + S + C, "first sleep entry")
        `CHECK(first_sleep < PON, 1'b1, "first output late")
        `CHECK(next_wake, P + 1, "wake spacing")
        `CHECK(overlap, 0, "phase overlap")
        `CHECK(out_level_out, 1'b1, "output with no field")
        $display("test phase_walk done");
        wait_sleep(1'b1);
        // Inputs change only while asleep; the next wake must pick them up
        foreach (rows[i])
        begin
            mode = rows[i].mode;
            code = rows[i].code;
            flux = rows[i].flux;
            wait_sleep(1'b0);
            wait_sleep(1'b1);
            `CHECK(out_level_out, rows[i].exp, "threshold decision")
        end
        $display("test threshold_rows done");
        mode = set_resistor;
        code = 16'h1388;
        flux = 16'sh1770;
        wait_sleep(1'b0);
        wait_sleep(1'b1);
        `CHECK(out_level_out, 1'b0, "operated before reset")
        reset_n_in = 1'b0;
        #1;
        `CHECK({out_level_out, sleep_out}, 2'h3, "mid-run reset")
        repeat (2) @(posedge clk_in);
        #1;
        reset_n_in = 1'b1;
        wait_sleep(1'b0);
        wait_sleep(1'b1);
        `CHECK(out_level_out, 1'b0, "first sample after reset")
        $display("test mid_reset done");
        end_of_test();
    end
endmodule : tb
